// File: fqsc_pkg.sv
// Package for the free queue starvation counter bank.
package fqsc_pkg;
    localparam int FQSC_NUM_QUEUES = 12;
    localparam int FQSC_CNT_W = 8;
    localparam int FQSC_REG_W = 16;
    localparam int FQSC_ADDR_W = 4;
    localparam int FQSC_LO_LSB = 0;
    localparam int FQSC_HI_LSB = 8;
    localparam logic [7:0] FQSC_CNT_RESET = 8'h00;
    localparam logic [7:0] FQSC_CNT_MAX = 8'hFF;
    localparam logic [31:0] FQSC_UNMAPPED_DATA = 32'h0000_0000;
    // Word offsets of the counter registers and the status register.
    localparam logic [3:0] FQSC_OFF_Q0_Q1 = 4'h0;
    localparam logic [3:0] FQSC_OFF_Q2_Q3 = 4'h1;
    localparam logic [3:0] FQSC_OFF_Q4_Q5 = 4'h2;
    localparam logic [3:0] FQSC_OFF_Q6_Q7 = 4'h3;
    localparam logic [3:0] FQSC_OFF_Q8_Q9 = 4'h4;
    localparam logic [3:0] FQSC_OFF_Q10_Q11 = 4'h5;
    localparam logic [3:0] FQSC_OFF_STATUS = 4'h6;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } fqsc_avm_req_t;

    typedef struct packed {
        logic waitrequest;
        logic readdatavalid;
        logic [31:0] readdata;
    } fqsc_avm_rsp_t;

    typedef enum logic [1:0] {
        FQSC_IDLE,
        FQSC_ANSWER
    } fqsc_bus_state_t;
endpackage

// File: fqsc_counter.sv
// One saturating event counter with clear on read.
`timescale 1ns/1ps
`default_nettype none
module fqsc_counter
    import fqsc_pkg::*;
#(
    parameter int WIDTH = FQSC_CNT_W
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic event_in,
    input wire logic clear_in,
    output var logic [WIDTH-1:0] count_r
);
    logic [WIDTH-1:0] count_nxt;
    wire at_max = &count_r;
    // A pop on the clearing cycle restarts at one so it is not lost.
    assign count_nxt = clear_in ? WIDTH'(event_in) :
        ((event_in && !at_max) ? count_r + 1'b1 : count_r); // RL1 RL6

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_r <= '0;
        end else if (clk_en) begin
            count_r <= count_nxt;
        end
    end
endmodule
`default_nettype wire

// File: fqsc_avalon_slave.sv
// Avalon-MM slave handshake with a fixed one-cycle wait.
`timescale 1ns/1ps
`default_nettype none
module fqsc_avalon_slave
    import fqsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire fqsc_avm_req_t req,
    output var logic accept,
    output var logic waitrequest
);
    fqsc_bus_state_t state_r;
    fqsc_bus_state_t state_nxt;
    wire active = req.read || req.write;

    // The request stands one idle cycle so read data are registered first.
    assign accept = clk_en && (state_r == FQSC_ANSWER) && active;
    assign waitrequest = !(state_r == FQSC_ANSWER);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FQSC_IDLE: begin
                if (active) begin
                    state_nxt = FQSC_ANSWER;
                end
            end
            FQSC_ANSWER: begin
                state_nxt = FQSC_IDLE;
            end
            default: begin
                state_nxt = FQSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= FQSC_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end
endmodule
`default_nettype wire

// File: fqsc_top.sv
// Free queue starvation counter bank with Avalon-MM register access.
// Operation
// RL1 - Each free queue has an 8-bit counter that adds one on a pop while empty.
// RL2 - A read of a counter register returns both counters and then clears both.
// RL3 - Software uses only full 16-bit word accesses, never byte accesses.
// RL4 - Register k holds the counter of queue 2k in bits 7 to 0.
// RL5 - Register k holds queue 2k+1 in bits 15 to 8, each counted on its own.
// RL6 - Counters saturate at 0xFF and a pop on a clearing read leaves one.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fqsc_top
    import fqsc_pkg::*;
#(
    parameter int NUM_QUEUES = FQSC_NUM_QUEUES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [NUM_QUEUES-1:0] queue_pop,
    input wire logic [NUM_QUEUES-1:0] queue_empty,
    input wire logic [FQSC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output var logic [31:0] avs_readdata,
    output var logic avs_waitrequest,
    output var logic byte_access_seen
);
    localparam int NUM_REGS = NUM_QUEUES / 2;

    fqsc_avm_req_t req;
    logic accept;
    logic wait_c;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic waitrequest_r;
    logic byte_seen_r;
    logic [FQSC_CNT_W-1:0] count [NUM_QUEUES];
    logic [NUM_QUEUES-1:0] clear_vec;
    logic [NUM_QUEUES-1:0] event_vec;
    logic [NUM_REGS-1:0] reg_hit;

    function automatic logic [FQSC_REG_W-1:0] pack_pair(
        input logic [FQSC_CNT_W-1:0] lo,
        input logic [FQSC_CNT_W-1:0] hi
    );
        pack_pair = {hi, lo}; // RL4 RL5
    endfunction

    assign req.read = avs_read;
    assign req.write = avs_write;
    assign req.address = avs_address;
    assign req.byteenable = avs_byteenable;
    assign req.writedata = avs_writedata;

    fqsc_avalon_slave u_slave (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .req(req),
        .accept(accept),
        .waitrequest(wait_c)
    );

    assign event_vec = queue_pop & queue_empty; // RL1

    // The pair clears on the edge that captures its read data, so a pop
    // on that edge restarts the count at one instead of being lost.
    wire capture_rd = clk_en && waitrequest_r && avs_read;

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_reg
            assign reg_hit[g] = (avs_address == FQSC_ADDR_W'(g));
            assign clear_vec[2*g] = capture_rd && reg_hit[g]; // RL2
            assign clear_vec[2*g+1] = clear_vec[2*g]; // RL2
        end
        for (g = 0; g < NUM_QUEUES; g++) begin : g_cnt
            fqsc_counter #(.WIDTH(FQSC_CNT_W)) u_cnt (
                .clk_sys(clk_sys),
                .reset(reset),
                .clk_en(clk_en),
                .event_in(event_vec[g]),
                .clear_in(clear_vec[g]),
                .count_r(count[g])
            );
        end
    endgenerate

    // Read data are captured on the same edge that clears the pair.
    always_comb begin
        readdata_nxt = FQSC_UNMAPPED_DATA;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (reg_hit[i]) begin
                readdata_nxt = {16'h0000,
                    pack_pair(count[2*i], count[2*i+1])}; // RL2
            end
        end
        if (avs_address == FQSC_OFF_STATUS) begin
            readdata_nxt = {31'h0000_0000, byte_seen_r};
        end
    end

    wire partial = (avs_read || avs_write) &&
        (avs_byteenable[1:0] != 2'b11);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            readdata_r <= 32'h0000_0000;
            waitrequest_r <= 1'b1;
            byte_seen_r <= 1'b0;
        end else if (clk_en) begin
            readdata_r <= readdata_nxt;
            waitrequest_r <= !(wait_c && (avs_read || avs_write));
            // Byte access is unsupported; flag it sticky for software.
            if (accept && partial) begin
                byte_seen_r <= 1'b1; // RL3
            end else if (accept && avs_write &&
                avs_address == FQSC_OFF_STATUS && avs_writedata[0]) begin
                byte_seen_r <= 1'b0;
            end
        end
    end

    assign avs_readdata = readdata_r;
    // Low only in the answer cycle; a flop keeps decode glitches off the pin.
    assign avs_waitrequest = waitrequest_r;
    assign byte_access_seen = byte_seen_r;
endmodule
`default_nettype wire

// File: fqsc_top_chk.sv
// Port checks on the starvation counter bank.
`timescale 1ns/1ps
`default_nettype none
module fqsc_top_chk
    import fqsc_pkg::*;
#(
    parameter int NUM_QUEUES = FQSC_NUM_QUEUES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [NUM_QUEUES-1:0] queue_pop,
    input wire logic [NUM_QUEUES-1:0] queue_empty,
    input wire logic [FQSC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic byte_access_seen
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic req = avs_read || avs_write;
    wire logic rd_done = avs_read && !avs_waitrequest;
    wire logic odd_be = avs_byteenable[1:0] != 2'b11;
    AST_WAIT_ONE: assert property (clk_en && req && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    AST_LOW_ONCE: assert property (clk_en && !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");
    AST_IDLE_HIGH: assert property (clk_en && !req |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    AST_UPPER_ZERO: assert property (rd_done |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper half of read data not zero");
    AST_FLAG_SET: assert property (rd_done && odd_be |-> ##[0:2] byte_access_seen)
        else $error("byte access not flagged");
    AST_FLAG_HOLD: assert property (byte_access_seen && !avs_write |=> byte_access_seen)
        else $error("byte access flag dropped");
endmodule
bind fqsc_top fqsc_top_chk #(.NUM_QUEUES(NUM_QUEUES)) i_chk (.clk_sys(clk_sys),
    .reset(reset), .clk_en(clk_en), .queue_pop(queue_pop),
    .queue_empty(queue_empty), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .byte_access_seen(byte_access_seen));
`default_nettype wire

// File: fqsc_qm_model.sv
// Queue manager model that issues pop strobes with empty levels.
`timescale 1ns/1ps
`default_nettype none
module fqsc_qm_model
    import fqsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [FQSC_NUM_QUEUES-1:0] pop_cmd,
    input wire logic [FQSC_NUM_QUEUES-1:0] empty_cmd,
    output logic [FQSC_NUM_QUEUES-1:0] queue_pop,
    output logic [FQSC_NUM_QUEUES-1:0] queue_empty
);
    // Both leave on one edge, so a pop never sees a stale empty level.
    always_ff @(posedge clk_sys) begin
        queue_pop <= pop_cmd;
        queue_empty <= empty_cmd;
    end
endmodule
`default_nettype wire

// File: free_queue_starvation_counters_tb_top.sv
// Self-checking bench for the starvation counter bank.
`timescale 1ns/1ps
`default_nettype none
module free_queue_starvation_counters_tb_top import fqsc_pkg::*;;
    logic clk_sys = 0, reset = 1, avs_read = 0, avs_write = 0;
    logic avs_waitrequest, byte_access_seen;
    logic [11:0] pop_cmd = '0, empty_cmd = '0, queue_pop, queue_empty;
    logic [3:0] avs_address = '0, avs_byteenable = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, d;
    int miscompares = 0, cmp_count = 0, k;
    always #20 clk_sys = ~clk_sys;
    fqsc_qm_model i_qm (.clk_sys(clk_sys), .pop_cmd(pop_cmd),
        .empty_cmd(empty_cmd), .queue_pop(queue_pop),
        .queue_empty(queue_empty));
    fqsc_top i_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1),
        .queue_pop(queue_pop), .queue_empty(queue_empty),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .byte_access_seen(byte_access_seen));
    task automatic chk(input string w, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic acc(input logic wr, input logic [3:0] a, be,
        input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_byteenable <= be;
        avs_writedata <= wd;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic rdc(input logic [3:0] a, be, input logic [31:0] e);
        acc(0, a, be, 32'h0000_0000);
        chk("readdata", e, d);
    endtask
    // Each pop is a one-cycle strobe with a quiet cycle after it, as the
    // queue manager gives them.
    task automatic pops(input logic [11:0] m, em, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            pop_cmd <= m;
            empty_cmd <= em;
            @(posedge clk_sys);
            pop_cmd <= '0;
        end
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 0;
        for (k = 0; k < 6; k++) rdc(k, 4'hf, 32'h0000_0000);
        for (k = 0; k < 12; k++) pops(12'h001 << k, 12'hfff, k + 1);
        pops(12'hfff, 12'h000, 2);
        for (k = 0; k < 6; k++) begin
            rdc(k, 4'h3, {16'h0000, 8'(2 * k + 2), 8'(2 * k + 1)});
            rdc(k, 4'hf, 32'h0000_0000);
        end
        pops(12'h008, 12'hfff, 260);
        rdc(1, 4'hf, 32'h0000_ff00);
        pops(12'h001, 12'hfff, 1);
        acc(1, 0, 4'hf, 32'h0000_5555);
        rdc(0, 4'hf, 32'h0000_0001);
        rdc(9, 4'hf, 32'h0000_0000);
        rdc(0, 4'h1, 32'h0000_0000);
        // The flag is set on the edge that completes the access.
        @(posedge clk_sys);
        chk("byte_access_seen", 1, {31'h0, byte_access_seen});
        rdc(FQSC_OFF_STATUS, 4'hf, 32'h0000_0001);
        acc(1, FQSC_OFF_STATUS, 4'hf, 32'h0000_0001);
        rdc(FQSC_OFF_STATUS, 4'hf, 32'h0000_0000);
        acc(1, FQSC_OFF_STATUS, 4'h1, 32'h0000_0001);
        rdc(FQSC_OFF_STATUS, 4'hf, 32'h0000_0001);
        // Queue 0 pops in the capture cycle, queue 1 in the answer cycle.
        @(posedge clk_sys);
        empty_cmd <= 12'hfff;
        pop_cmd <= 12'h001;
        fork
            rdc(0, 4'hf, 32'h0000_0000);
            begin
                @(posedge clk_sys);
                pop_cmd <= 12'h002;
                @(posedge clk_sys);
                pop_cmd <= '0;
            end
        join
        rdc(0, 4'hf, 32'h0000_0101);
        finish_test;
    end
    initial begin
        #400000;
        miscompares++;
        finish_test;
    end
endmodule
`default_nettype wire
